// ### verilog/clc_limit_regs.sv
`timescale 1ns/1ns
module clc_limit_regs
  import clc_pkg::*;
(
  input wire logic core_clk_i, // 25 MHz clock
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic reg_wr_i, // Register write strobe
  input wire logic reg_rd_i, // Register read strobe
  input wire logic [7:0] reg_addr_i, // Register address, whole device map
  input wire logic [7:0] reg_wdata_i, // Write data
  output logic [7:0] reg_rdata_o, // Read data, valid cycle after read
  input wire logic sense_below_short_i, // Sense output below short threshold
  input wire logic charging_i, // Charger in charge mode
  input wire logic [3:0] charge_current_code_i, // Programmed charge current code
  input wire logic limit_source_select_i, // Limit-select bit
  input wire logic port_detect_charger_i, // Detection result: 1 charger, 0 std port
  input wire logic mode_pin_i, // External mode pin level
  output logic [9:0] input_limit_ma_o, // Applied input limit, all ones unlimited
  output logic [12:0] reg_voltage_mv_o, // Applied battery regulation voltage
  output logic [5:0] boost_code_o, // Saturated boost voltage code
  output logic [4:0] charge_sense_mv_o, // Applied charge sense voltage
  output logic [12:0] input_vreg_mv_o, // Input voltage regulation level
  output logic short_ref_external_o, // Threshold pin current source on
  output logic mode_pin_active_o, // Mode pin enabled and asserted
  output logic term_enable_o, // Charge termination enabled
  output logic safety_locked_o // Safety register write-locked
);

  // ==========================================================
  // Decode functions
  function automatic logic [4:0] sense_mv(input logic [3:0] code);
    logic [3:0] c;
    c = (code > SENSE_SAT_CODE) ? SENSE_SAT_CODE : code;
    sense_mv = SENSE_BASE_MV + 5'(SENSE_STEP_MV * {1'b0, c});
  endfunction

  function automatic logic [12:0] reg_mv(input logic [5:0] code);
    logic [5:0] c;
    c = (code > REG_VOLT_SAT_CODE) ? REG_VOLT_SAT_CODE : code;
    reg_mv = REG_VOLT_BASE_MV + 13'(REG_VOLT_STEP_MV * {7'h00, c});
  endfunction

  function automatic logic [12:0] max_reg_mv(input logic [3:0] code);
    logic [3:0] c;
    c = (code > MAX_REG_SAT_CODE) ? MAX_REG_SAT_CODE : code;
    max_reg_mv = MAX_REG_BASE_MV + 13'(REG_VOLT_STEP_MV * {9'h000, c});
  endfunction

  // ==========================================================
  // Registers
  logic [7:0] input_limit_and_regulation_voltage;
  logic [7:0] charge_options_and_input_regulation;
  logic [7:0] safety_limit_current_voltage;
  logic safety_locked;
  logic wr_b;
  logic wr_c;
  logic wr_d;
  logic wr_other;

  assign wr_b = reg_wr_i && (reg_addr_i == ADDR_INPUT_LIMIT_AND_REGULATION_VOLTAGE);
  assign wr_c = reg_wr_i && (reg_addr_i == ADDR_CHARGE_OPTIONS_AND_INPUT_REGULATION);
  assign wr_d = reg_wr_i && (reg_addr_i == ADDR_SAFETY_LIMIT_CURRENT_VOLTAGE);
  assign wr_other = reg_wr_i && !wr_d;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      input_limit_and_regulation_voltage <= RST_INPUT_LIMIT_AND_REGULATION_VOLTAGE;
    end else if (wr_b) begin
      input_limit_and_regulation_voltage <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      charge_options_and_input_regulation <= RST_CHARGE_OPTIONS_AND_INPUT_REGULATION;
    end else if (wr_c) begin
      charge_options_and_input_regulation <= reg_wdata_i;
    end
  end

  // Safety register: reload on short, write only while unlocked
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      safety_limit_current_voltage <= RST_SAFETY_LIMIT_CURRENT_VOLTAGE;
    end else if (sense_below_short_i) begin
      safety_limit_current_voltage <= RST_SAFETY_LIMIT_CURRENT_VOLTAGE;
    end else if (wr_d && !safety_locked) begin
      safety_limit_current_voltage <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      safety_locked <= 1'b0;
    end else if (sense_below_short_i) begin
      safety_locked <= 1'b0;
    end else if (wr_other) begin
      safety_locked <= 1'b1;
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_INPUT_LIMIT_AND_REGULATION_VOLTAGE: reg_rdata_o <= input_limit_and_regulation_voltage;
        ADDR_CHARGE_OPTIONS_AND_INPUT_REGULATION: begin
          reg_rdata_o <= charge_options_and_input_regulation;
        end
        ADDR_SAFETY_LIMIT_CURRENT_VOLTAGE: reg_rdata_o <= safety_limit_current_voltage;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Applied limits
  logic [1:0] limit_code;
  logic [5:0] volt_code;
  logic [3:0] max_chg_code;
  logic [3:0] max_reg_code;
  logic [9:0] next_input_limit;
  logic [9:0] prog_limit;
  logic [9:0] det_limit;
  logic [12:0] next_reg_voltage;
  logic [4:0] next_charge_sense;

  assign limit_code = input_limit_and_regulation_voltage[INPUT_LIMIT_MSB:INPUT_LIMIT_LSB];
  assign volt_code = input_limit_and_regulation_voltage[REG_VOLT_MSB:0];
  assign max_chg_code = safety_limit_current_voltage[MAX_CHG_MSB:MAX_CHG_LSB];
  assign max_reg_code = safety_limit_current_voltage[MAX_REG_MSB:0];

  always_comb begin
    unique case (limit_code)
      2'h0: prog_limit = LIMIT_CODE0_MA;
      2'h1: prog_limit = LIMIT_CODE1_MA;
      2'h2: prog_limit = LIMIT_CODE2_MA;
      2'h3: prog_limit = LIMIT_NONE_MA;
    endcase
    det_limit = port_detect_charger_i ? DETECT_CHARGER_MA : DETECT_STD_MA;
    if (!limit_source_select_i && det_limit > prog_limit) begin
      next_input_limit = det_limit;
    end else begin
      next_input_limit = prog_limit;
    end
  end

  always_comb begin
    next_reg_voltage = reg_mv(volt_code);
    if (charging_i && max_reg_mv(max_reg_code) < next_reg_voltage) begin
      next_reg_voltage = max_reg_mv(max_reg_code);
    end
    next_charge_sense = sense_mv(charge_current_code_i);
    if (charging_i && sense_mv(max_chg_code) < next_charge_sense) begin
      next_charge_sense = sense_mv(max_chg_code);
    end
    if (charge_options_and_input_regulation[LOW_CURRENT_OVERRIDE_BIT]) begin
      next_charge_sense = LOW_CURRENT_OVERRIDE_SENSE_MV;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      input_limit_ma_o <= 10'h000;
      reg_voltage_mv_o <= 13'h0000;
      boost_code_o <= 6'h00;
      charge_sense_mv_o <= 5'h00;
      input_vreg_mv_o <= 13'h0000;
    end else begin
      input_limit_ma_o <= next_input_limit;
      reg_voltage_mv_o <= next_reg_voltage;
      boost_code_o <= (volt_code > REG_VOLT_SAT_CODE) ? REG_VOLT_SAT_CODE : volt_code;
      charge_sense_mv_o <= next_charge_sense;
      input_vreg_mv_o <= VIN_REG_BASE_MV + 13'(VIN_REG_STEP_MV *
        {10'h000, charge_options_and_input_regulation[VIN_REG_MSB:0]});
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      short_ref_external_o <= 1'b0;
      mode_pin_active_o <= 1'b0;
      term_enable_o <= 1'b0;
      safety_locked_o <= 1'b0;
    end else begin
      short_ref_external_o <= charge_options_and_input_regulation[SHORT_REF_BIT];
      mode_pin_active_o <= charge_options_and_input_regulation[MODE_EN_BIT] &&
        (mode_pin_i == charge_options_and_input_regulation[MODE_POL_BIT]);
      term_enable_o <= charge_options_and_input_regulation[TERM_EN_BIT];
      safety_locked_o <= safety_locked;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_short_reload: assert property (sense_below_short_i |=>
    safety_limit_current_voltage == RST_SAFETY_LIMIT_CURRENT_VOLTAGE && !safety_locked)
    else $error("safety register not reloaded on short");
  a_lock_other: assert property (wr_other && !sense_below_short_i |=> safety_locked)
    else $error("other write did not lock safety register");
  a_locked_hold: assert property (safety_locked && wr_d && !sense_below_short_i
    |=> $stable(safety_limit_current_voltage))
    else $error("locked safety register changed");
  a_first_write: assert property (!safety_locked && wr_d && !sense_below_short_i
    |=> safety_limit_current_voltage == $past(reg_wdata_i))
    else $error("unlocked safety write lost");
  a_low_charge: assert property (charge_options_and_input_regulation[LOW_CURRENT_OVERRIDE_BIT]
    |=> charge_sense_mv_o == LOW_CURRENT_OVERRIDE_SENSE_MV)
    else $error("low charge override not applied");
  a_volt_min: assert property (charging_i |=>
    reg_voltage_mv_o <= max_reg_mv($past(max_reg_code)))
    else $error("regulation voltage above safety maximum");
  a_chg_min: assert property (charging_i &&
    !charge_options_and_input_regulation[LOW_CURRENT_OVERRIDE_BIT]
    |=> charge_sense_mv_o <= sense_mv($past(max_chg_code)))
    else $error("charge current above safety maximum");
  a_term_write: assert property (wr_c |=> ##1
    term_enable_o == $past(reg_wdata_i[TERM_EN_BIT], 2))
    else $error("termination enable not following write");
  a_mode_off: assert property (!charge_options_and_input_regulation[MODE_EN_BIT]
    |=> !mode_pin_active_o)
    else $error("disabled mode pin reported active");
  a_limit_sel: assert property (limit_source_select_i && limit_code == 2'h0
    |=> input_limit_ma_o == LIMIT_CODE0_MA)
    else $error("programmed limit not applied");

  c_short: cover property (sense_below_short_i ##1 !sense_below_short_i ##[1:20] wr_d);
  c_lock: cover property (wr_other ##[1:20] wr_d);
  c_charge_min: cover property (charging_i && sense_mv(max_chg_code) <
    sense_mv(charge_current_code_i));
endmodule

// ### verilog/clc_pkg.sv
package clc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_INPUT_LIMIT_AND_REGULATION_VOLTAGE = 8'h02;
  localparam logic [7:0] ADDR_CHARGE_OPTIONS_AND_INPUT_REGULATION = 8'h03;
  localparam logic [7:0] ADDR_SAFETY_LIMIT_CURRENT_VOLTAGE = 8'h04;
  localparam logic [7:0] RST_INPUT_LIMIT_AND_REGULATION_VOLTAGE = 8'h19;
  localparam logic [7:0] RST_CHARGE_OPTIONS_AND_INPUT_REGULATION = 8'h8A;
  localparam logic [7:0] RST_SAFETY_LIMIT_CURRENT_VOLTAGE = 8'h40;
  // ==========================================================
  // Field positions
  localparam int INPUT_LIMIT_MSB = 7;
  localparam int INPUT_LIMIT_LSB = 6;
  localparam int REG_VOLT_MSB = 5;
  localparam int SHORT_REF_BIT = 7;
  localparam int MODE_POL_BIT = 6;
  localparam int MODE_EN_BIT = 5;
  localparam int TERM_EN_BIT = 4;
  localparam int LOW_CURRENT_OVERRIDE_BIT = 3;
  localparam int VIN_REG_MSB = 2;
  localparam int MAX_CHG_MSB = 7;
  localparam int MAX_CHG_LSB = 4;
  localparam int MAX_REG_MSB = 3;
  // ==========================================================
  // Decode constants
  localparam logic [9:0] LIMIT_CODE0_MA = 10'h064;
  localparam logic [9:0] LIMIT_CODE1_MA = 10'h1F4;
  localparam logic [9:0] LIMIT_CODE2_MA = 10'h3CF;
  localparam logic [9:0] LIMIT_NONE_MA = 10'h3FF;
  localparam logic [9:0] DETECT_STD_MA = 10'h1F4;
  localparam logic [9:0] DETECT_CHARGER_MA = 10'h3E8;
  localparam logic [12:0] REG_VOLT_BASE_MV = 13'h0DAC;
  localparam logic [12:0] REG_VOLT_STEP_MV = 13'h0014;
  localparam logic [5:0] REG_VOLT_SAT_CODE = 6'h2F;
  localparam logic [5:0] BOOST_5V_CODE = 6'h19;
  localparam logic [12:0] MAX_REG_BASE_MV = 13'h1068;
  localparam logic [3:0] MAX_REG_SAT_CODE = 4'hC;
  localparam logic [12:0] VIN_REG_BASE_MV = 13'h1068;
  localparam logic [12:0] VIN_REG_STEP_MV = 13'h0050;
  localparam logic [4:0] SENSE_BASE_MV = 5'h0B;
  localparam logic [4:0] SENSE_STEP_MV = 5'h02;
  localparam logic [3:0] SENSE_SAT_CODE = 4'hA;
  localparam logic [4:0] LOW_CURRENT_OVERRIDE_SENSE_MV = 5'h03;
endpackage

// ### verification/clc_host_model.sv
`timescale 1ns/1ns
module clc_host_model (
  input wire logic core_clk_i, // System clock
  output logic reg_wr_o, // Write strobe
  output logic reg_rd_o, // Read strobe
  output logic [7:0] reg_addr_o, // Register address
  output logic [7:0] reg_wdata_o, // Write data
  input wire logic [7:0] reg_rdata_i // Read data
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // ==========================================================
  // Bus cycles; idle bus shows the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge core_clk_i);
    #1;
    d = reg_rdata_i;
  endtask
endmodule

// ### verification/clc_limit_regs_tb.sv
`timescale 1ns/1ns
module clc_limit_regs_tb;
  import clc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_s, rd_s, below = 1'b0, chg = 1'b0, lsel = 1'b1, det = 1'b0, pin = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] ccode = 4'h5;
  logic [9:0] lim;
  logic [12:0] vreg, vin;
  logic [5:0] boost;
  logic [4:0] sense;
  logic ref_ext, active, term, locked;
  int err_total = 0;
  int n_checks = 0;
  logic [9:0] lim_tab [4] = '{10'h064, 10'h1F4, 10'h3CF, 10'h3FF};
  always #20 clk = ~clk;
  clc_host_model clc_host_model_inst (.core_clk_i(clk), .reg_wr_o(wr_s), .reg_rd_o(rd_s),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  clc_limit_regs clc_limit_regs_inst (.core_clk_i(clk), .sys_rst_i(rst), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .sense_below_short_i(below), .charging_i(chg), .charge_current_code_i(ccode),
    .limit_source_select_i(lsel), .port_detect_charger_i(det), .mode_pin_i(pin),
    .input_limit_ma_o(lim), .reg_voltage_mv_o(vreg), .boost_code_o(boost),
    .charge_sense_mv_o(sense), .input_vreg_mv_o(vin), .short_ref_external_o(ref_ext),
    .mode_pin_active_o(active), .term_enable_o(term), .safety_locked_o(locked));
  // ==========================================================
  // Checking helpers
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    clc_host_model_inst.rd(a, d);
    chk({5'h00, d}, {5'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    clc_host_model_inst.wr(a, d);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic mode_case(input logic [7:0] v, input logic p, input logic [3:0] exp);
    wr(ADDR_CHARGE_OPTIONS_AND_INPUT_REGULATION, v);
    pin <= p;
    settle();
    chk({12'h000, active}, {12'h000, exp[3]});
    chk({12'h000, ref_ext}, {12'h000, exp[2]});
    chk({12'h000, term}, {12'h000, exp[1]});
    chk(vin, VIN_REG_BASE_MV + 13'(v[2:0]) * VIN_REG_STEP_MV);
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk({3'h0, lim}, 13'h0064);
    chk(vreg, 13'h0FA0);
    chk({7'h00, boost}, 13'h0019);
    chk({8'h00, sense}, 13'h0003);
    chk(vin, 13'h1108);
    chk({12'h000, ref_ext}, 13'h0001);
    chk({12'h000, locked}, 13'h0000);
    rdc(8'h02, 8'h19);
    rdc(8'h03, 8'h8A);
    rdc(8'h04, 8'h40);
    rdc(8'h10, 8'h00);
    $display("defaults test done");
    wr(8'h04, 8'h5C);
    rdc(8'h04, 8'h5C);
    wr(8'h01, 8'h00);
    settle();
    chk({12'h000, locked}, 13'h0001);
    wr(8'h04, 8'h00);
    rdc(8'h04, 8'h5C);
    $display("lock test done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h02, {i[1:0], 6'h19});
      settle();
      chk({3'h0, lim}, {3'h0, lim_tab[i]});
    end
    @(posedge clk);
    lsel <= 1'b0;
    det <= 1'b1;
    wr(8'h02, 8'h19);
    settle();
    chk({3'h0, lim}, 13'h03E8);
    @(posedge clk);
    det <= 1'b0;
    wr(8'h02, 8'h99);
    settle();
    chk({3'h0, lim}, 13'h03CF);
    $display("input limit test done");
    @(posedge clk);
    chg <= 1'b1;
    ccode <= 4'hA;
    wr(8'h03, 8'h02);
    settle();
    chk({8'h00, sense}, 13'h0015);
    @(posedge clk);
    ccode <= 4'h4;
    settle();
    chk({8'h00, sense}, 13'h0013);
    wr(8'h02, 8'h3F);
    settle();
    chk(vreg, 13'h1158);
    chk({7'h00, boost}, 13'h002F);
    wr(8'h02, 8'h00);
    settle();
    chk(vreg, 13'h0DAC);
    chk({7'h00, boost}, 13'h0000);
    $display("charging test done");
    @(posedge clk);
    below <= 1'b1;
    settle();
    @(posedge clk);
    below <= 1'b0;
    rdc(8'h04, 8'h40);
    chk({12'h000, locked}, 13'h0000);
    wr(8'h04, 8'h01);
    wr(8'h02, 8'h3F);
    settle();
    chk(vreg, 13'h107C);
    chk({8'h00, sense}, 13'h000B);
    chk({12'h000, locked}, 13'h0001);
    $display("short test done");
    mode_case(8'hF7, 1'b1, 4'hE);
    mode_case(8'hF7, 1'b0, 4'h6);
    mode_case(8'h20, 1'b0, 4'h8);
    mode_case(8'h08, 1'b0, 4'h0);
    chk({8'h00, sense}, 13'h0003);
    $display("mode test done");
    // Mid-run reset: lock must clear, then wrong write order keeps defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk({12'h000, locked}, 13'h0000);
    wr(8'h03, 8'h8A);
    wr(8'h04, 8'h5C);
    rdc(8'h04, 8'h40);
    $display("reset test done");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end
endmodule
